// ### pkg/swc_pkg.sv
// Constants and types for the standby and wake controller.
// Assumes a 20 MHz system clock and a classic Wishbone slave port.
package swc_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_TRIG = 8'h0c;
  localparam logic [7:0] OFF_OSC = 8'h10;
  localparam logic [7:0] OFF_P0EN = 8'h14;
  localparam logic [7:0] OFF_BT = 8'h18;
  localparam logic [7:0] OFF_STATE = 8'h1c;
  // Standby request codes in the control register
  localparam logic [1:0] REQ_NONE = 2'h0;
  localparam logic [1:0] REQ_PAUSE = 2'h1;
  localparam logic [1:0] REQ_SLEEP = 2'h2;
  localparam logic [1:0] REQ_XSLEEP = 2'h3;
  // Trigger codes per external line
  localparam logic [2:0] TRG_RISE = 3'h0;
  localparam logic [2:0] TRG_FALL = 3'h1;
  localparam logic [2:0] TRG_BOTH = 3'h2;
  localparam logic [2:0] TRG_HIGH = 3'h3;
  localparam logic [2:0] TRG_LOW = 3'h4;
  // Base timer clock source select
  localparam logic [1:0] BTS_SUB = 2'h0;
  localparam logic [1:0] BTS_SYS = 2'h1;
  localparam logic [1:0] BTS_PRE = 2'h2;
  // Status bit positions
  localparam int unsigned ST_EXT = 0;
  localparam int unsigned ST_P0 = 1;
  localparam int unsigned ST_BT = 2;
  localparam int unsigned ST_IR = 3;
  localparam int unsigned ST_WAKE = 4;
  localparam int unsigned ST_W = 5;
  localparam int unsigned SUBCLK_HZ_X1000 = 32_768_000;
  localparam int unsigned OSC_STABLE_US = 100;
  localparam int unsigned OSC_STABLE_CYC =
    (OSC_STABLE_US * (CLK_HZ / 1_000_000) > 0) ?
    OSC_STABLE_US * (CLK_HZ / 1_000_000) : 1;
  localparam int unsigned NF_LEN = 3;
  typedef enum logic [2:0] {
    SWC_RUN, SWC_PAUSE, SWC_SLEEP, SWC_XSLEEP, SWC_SETTLE
  } swc_state_t;
endpackage

// ### sim/swc_top_sva.sv
// Port checks for the standby controller.
// Assumes one clock domain and bind to swc_top.
`timescale 1ns/1ps
`default_nettype none
module swc_top_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic reset_pin_n,
  input wire logic other_irq,
  input wire logic core_run,
  input wire logic periph_run,
  input wire logic serial_run,
  input wire logic bt_run,
  input wire logic ir_run,
  input wire logic ceramic_osc_en,
  input wire logic internal_resistor_cap_osc_en,
  input wire logic tunable_osc_en,
  input wire logic crystal_osc_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic aft_r;
  wire pz = !core_run && periph_run && !aft_r;
  wire sl = !periph_run && !bt_run;
  wire xs = !periph_run && bt_run;
  wire fast = ceramic_osc_en | internal_resistor_cap_osc_en | tunable_osc_en;
  // Marks the settle phase after a sleep
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      aft_r <= 1'b0;
    else if (core_run)
      aft_r <= 1'b0;
    else if (!periph_run)
      aft_r <= 1'b1;
  sequence settle_done;
    ##[1:20] core_run;
  endsequence
  pause_serial_a: assert property (pz |-> !serial_run)
    else $error("serial logic runs in pause");
  pause_exit_a: assert property (pz && other_irq && ce |=> core_run)
    else $error("pause not left on irq");
  sleep_osc_a: assert property (sl |-> !fast && !crystal_osc_en)
    else $error("oscillator on in sleep");
  xsleep_run_a: assert property (xs |-> ir_run && !fast)
    else $error("crystal sleep run set wrong");
  xtal_hold_a: assert property (xs && $past(xs) |-> $stable(crystal_osc_en))
    else $error("crystal state changed");
  settle_hold_a: assert property (sl |=> !core_run)
    else $error("core ran without settle");
  sleep_exit_a: assert property (sl && !reset_pin_n && ce |-> settle_done)
    else $error("sleep not left on reset pin");
  ack_time_a: assert property (wb_cyc_i && wb_stb_i && ce && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
endmodule
bind swc_top swc_top_sva chk (.clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .reset_pin_n, .other_irq, .core_run, .periph_run,
  .serial_run, .bt_run, .ir_run, .ceramic_osc_en,
  .internal_resistor_cap_osc_en, .tunable_osc_en, .crystal_osc_en);
`default_nettype wire

// ### sim/swc_wake_src.sv
// Wake source model: reset pin, line A, line C, port 0, timer, infrared, irq.
// Assumes the bench changes src just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module swc_wake_src (
  input wire logic [2:0] src,
  output logic reset_pin_n,
  output logic ext_irq_line_a,
  output logic ext_irq_line_c,
  output logic [7:0] port0_in,
  output logic bt_irq,
  output logic ir_irq,
  output logic other_irq
);
  assign reset_pin_n = src != 3'h1;
  assign ext_irq_line_a = src != 3'h2;
  assign ext_irq_line_c = src == 3'h7;
  assign port0_in = {7'h7f, src != 3'h3};
  assign bt_irq = src == 3'h4;
  assign ir_irq = src == 3'h5;
  assign other_irq = src == 3'h6;
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the standby controller.
// Assumes swc_top with a short settle count and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import swc_pkg::*;
  localparam int SET = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic wb_ack_o, core_run, periph_run, serial_run, bt_run, ir_run;
  logic ceramic_osc_en, internal_resistor_cap_osc_en, tunable_osc_en;
  logic crystal_osc_en, ext_d_hit, irq, bt_clk_tick;
  logic ext_irq_line_d = 1'b0;
  logic [2:0] src = 3'h0;
  logic [7:0] wk [7] = '{8'h21, 8'h22, 8'h23, 8'h27, 8'h34, 8'h35, 8'h32};
  wire reset_pin_n, ext_irq_line_a, ext_irq_line_c;
  wire bt_irq, ir_irq, other_irq;
  wire [7:0] port0_in;
  int fail_count = 0;
  int compares = 0;
  swc_top #(.SETTLE_CYC(SET)) uut (
    .clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i(4'h1), .wb_dat_o, .wb_ack_o,
    .reset_pin_n, .ext_irq_line_a, .ext_irq_line_b(ext_irq_line_a),
    .ext_irq_line_c, .ext_irq_line_d, .ext_irq_line_e(ext_irq_line_c),
    .ext_irq_line_f(ext_irq_line_c), .port0_in, .subclk_tick(src[0]),
    .prescaler_tick(src[1]), .bt_irq, .ir_irq, .other_irq,
    .core_run, .periph_run, .serial_run, .bt_run, .ir_run,
    .ceramic_osc_en, .internal_resistor_cap_osc_en, .tunable_osc_en,
    .crystal_osc_en, .bt_clk_tick, .ext_d_hit, .irq);
  swc_wake_src ws (.src, .reset_pin_n, .ext_irq_line_a, .ext_irq_line_c,
    .port0_in, .bt_irq, .ir_irq, .other_irq);
  initial
    forever #25 clk = ~clk;
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] g, e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wt(input logic d, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((d ? ext_d_hit : core_run) !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      fail_count++;
      test_done();
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
    begin
      fail_count++;
      test_done();
    end
  endtask
  task automatic t_reset();
    logic [31:0] r;
    chk("core", core_run, 1);
    chk("osc", {ceramic_osc_en, internal_resistor_cap_osc_en,
      tunable_osc_en, crystal_osc_en}, 4'hf);
    wb(0, OFF_STATE, 0, r);
    chk("state", r, 32'(SWC_RUN));
    wb(1, 8'h40, 32'h0000_00ff, r);
    wb(0, 8'h40, 0, r);
    chk("unmapped", r, 0);
    wb(1, OFF_TRIG, 32'h0001_b4c4, r);
    wb(1, OFF_P0EN, 32'h0000_0001, r);
    $display("reset test done");
  endtask
  task automatic t_pause();
    int n;
    logic [31:0] r;
    wb(1, OFF_CTRL, 32'(REQ_PAUSE), r);
    tk(2);
    chk("core", core_run, 0);
    chk("per", periph_run, 1);
    chk("ser", serial_run, 0);
    chk("osc", {ceramic_osc_en, internal_resistor_cap_osc_en,
      tunable_osc_en, crystal_osc_en}, 4'hf);
    ce <= 1'b0;
    src <= 3'h6;
    tk(3);
    chk("freeze", core_run, 0);
    ce <= 1'b1;
    wt(0, n);
    src <= 3'h0;
    chk("exit", n, 2);
    $display("pause test done");
  endtask
  task automatic t_wake(input logic [7:0] w);
    int n;
    logic [31:0] r;
    logic x;
    x = w[4];
    wb(1, OFF_CTRL, {28'h000_0000, w[7:4]}, r);
    tk(2);
    chk("per", periph_run, 0);
    chk("bt", bt_run, x);
    chk("ir", ir_run, x);
    chk("osc", {ceramic_osc_en, internal_resistor_cap_osc_en,
      tunable_osc_en}, 0);
    chk("xtal", crystal_osc_en, x);
    src <= w[2:0];
    wt(0, n);
    src <= 3'h0;
    chk("settle", n > SET, 1);
    wb(0, OFF_STATE, 0, r);
    chk("state", r, 32'(SWC_RUN));
    $display("wake test %h done", w);
  endtask
  task automatic t_irq();
    logic [31:0] r;
    wb(0, OFF_STAT, 0, r);
    chk("woke", r[ST_WAKE], 1);
    chk("irq off", irq, 0);
    wb(1, OFF_MASK, 32'h0000_0010, r);
    tk(1);
    chk("irq on", irq, 1);
    wb(1, OFF_STAT, 32'h0000_001f, r);
    tk(1);
    chk("irq clr", irq, 0);
    $display("irq test done");
  endtask
  task automatic t_line_d();
    int n;
    logic seen;
    logic [31:0] r;
    ext_irq_line_d <= 1'b1;
    wt(1, n);
    chk("d rise", n <= NF_LEN + 2, 1);
    tk(2);
    ext_irq_line_d <= 1'b0;
    wt(1, n);
    chk("d fall", n <= NF_LEN + 2, 1);
    tk(2);
    ext_irq_line_d <= 1'b1;
    tk(1);
    ext_irq_line_d <= 1'b0;
    seen = 1'b0;
    repeat (10)
    begin
      @(posedge clk);
      seen |= ext_d_hit;
    end
    chk("glitch", seen, 0);
    wb(1, OFF_TRIG, 32'h0001_b6c4, r);
    ext_irq_line_d <= 1'b1;
    wt(1, n);
    tk(1);
    chk("d level", ext_d_hit, 0);
    ext_irq_line_d <= 1'b0;
    $display("line d test done");
  endtask
  task automatic t_btsrc();
    logic [31:0] r;
    wb(1, OFF_BT, 32'(BTS_SYS), r);
    tk(1);
    chk("bt sys", bt_clk_tick, 1);
    wb(1, OFF_BT, 32'(BTS_SUB), r);
    src <= 3'h1;
    tk(1);
    chk("bt sub", bt_clk_tick, 1);
    wb(1, OFF_BT, 32'(BTS_PRE), r);
    tk(1);
    chk("bt pre lo", bt_clk_tick, 0);
    src <= 3'h2;
    tk(1);
    chk("bt pre hi", bt_clk_tick, 1);
    src <= 3'h0;
    $display("base timer source test done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_pause();
    foreach (wk[i])
      t_wake(wk[i]);
    t_irq();
    t_btsrc();
    t_line_d();
    test_done();
  end
endmodule
`default_nettype wire

// ### verilog/swc_edge_det.sv
// Per-line trigger detector with optional noise filter.
// Assumes the input pin is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module swc_edge_det
  import swc_pkg::*;
#(
  parameter int FILT = 0,
  parameter int NF = NF_LEN
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pin,
  input wire logic [2:0] trig,
  output logic hit
);
  logic [NF-1:0] hist_r;
  logic filt_r;
  logic prev_r;
  logic [NF+1:0] arm_r;
  wire all_hi = &hist_r;
  wire all_lo = ~|hist_r;
  wire cur = (FILT != 0) ? filt_r : pin;
  // Edges ignored until the history holds real samples
  wire armed = (FILT != 0) ? arm_r[NF+1] : arm_r[0];
  wire rise = armed & cur & ~prev_r;
  wire fall = armed & ~cur & prev_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hist_r <= '0;
      filt_r <= 1'b0;
      prev_r <= 1'b0;
      arm_r <= '0;
    end
    else if (ce)
    begin
      arm_r <= {arm_r[NF:0], 1'b1};
      hist_r <= {hist_r[NF-2:0], pin};
      if (all_hi)
        filt_r <= 1'b1;
      else if (all_lo)
        filt_r <= 1'b0;
      prev_r <= cur;
    end
  end
  always_comb
  begin
    case (trig)
      TRG_RISE: hit = rise;
      TRG_FALL: hit = fall;
      TRG_BOTH: hit = rise | fall;
      TRG_HIGH: hit = cur;
      TRG_LOW: hit = ~cur;
      default: hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ### verilog/swc_top.sv
// Standby and wake controller: pause, sleep and crystal sleep states.
// Assumes a classic Wishbone master and pins synchronous to clk.
// Overview of operation
// R01 - Pause state stops the core while peripherals keep running.
// R02 - Pause state stops part of the serial transfer logic.
// R03 - Entering pause leaves every oscillator running.
// R04 - Pause ends on system reset or any interrupt.
// R05 - Sleep stops core, peripherals and all four oscillators.
// R06 - Sleep ends on reset pin low, lines A B C E F, or port 0.
// R07 - Crystal sleep keeps only base timer and infrared receiver running.
// R08 - Crystal sleep stops ceramic, RC and tunable oscillators.
// R09 - Crystal sleep keeps the crystal in its state at entry.
// R10 - Crystal sleep also ends on base timer or infrared wake.
// R11 - Each port 0 pin is a wake input and interrupt source.
// R12 - Lines A and B offer edge and level triggers, no both-edge.
// R13 - Line D offers rising, falling and both edges only.
// R14 - Line D passes a noise filter before edge detection.
// R15 - Base timer clocks from subclock, system clock or prescaler.
// R16 - Infrared receiver can end crystal sleep.
// R17 - After oscillator-stopping sleep, hold core until clock settles.
// R18 - Software enters one low-power state by a control write.
`timescale 1ns/1ps
`default_nettype none
module swc_top
  import swc_pkg::*;
#(
  parameter int P0_W = 8,
  parameter int SETTLE_CYC = OSC_STABLE_CYC
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [swc_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reset_pin_n,
  input wire logic ext_irq_line_a,
  input wire logic ext_irq_line_b,
  input wire logic ext_irq_line_c,
  input wire logic ext_irq_line_d,
  input wire logic ext_irq_line_e,
  input wire logic ext_irq_line_f,
  input wire logic [P0_W-1:0] port0_in,
  input wire logic subclk_tick,
  input wire logic prescaler_tick,
  input wire logic bt_irq,
  input wire logic ir_irq,
  input wire logic other_irq,
  output logic core_run,
  output logic periph_run,
  output logic serial_run,
  output logic bt_run,
  output logic ir_run,
  output logic ceramic_osc_en,
  output logic internal_resistor_cap_osc_en,
  output logic tunable_osc_en,
  output logic crystal_osc_en,
  output logic bt_clk_tick,
  output logic ext_d_hit,
  output logic irq
);
  swc_state_t st_r, st_nxt;
  logic [1:0] ctrl_req_r;
  logic [ST_W-1:0] stat_r, mask_r;
  logic [17:0] trig_r;
  logic [3:0] osc_r;
  logic xtal_keep_r;
  logic [P0_W-1:0] p0en_r, p0_prev_r;
  logic [1:0] bts_r;
  logic [15:0] settle_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic hit_a, hit_b, hit_c, hit_d, hit_e, hit_f;

  // Per-line detectors; A and B may not use both-edge
  swc_edge_det u_a (.clk(clk), .rst_n(rst_n), .ce(ce), .pin(ext_irq_line_a),
    .trig(trig_r[2:0] == TRG_BOTH ? TRG_RISE : trig_r[2:0]), .hit(hit_a)); // [R12]
  swc_edge_det u_b (.clk(clk), .rst_n(rst_n), .ce(ce), .pin(ext_irq_line_b),
    .trig(trig_r[5:3] == TRG_BOTH ? TRG_RISE : trig_r[5:3]), .hit(hit_b)); // [R12]
  swc_edge_det u_c (.clk(clk), .rst_n(rst_n), .ce(ce), .pin(ext_irq_line_c),
    .trig(trig_r[8:6]), .hit(hit_c));
  swc_edge_det #(.FILT(1)) u_d (.clk(clk), .rst_n(rst_n), .ce(ce), // [R14]
    .pin(ext_irq_line_d), .trig(lim_d(trig_r[11:9])), .hit(hit_d)); // [R13]
  swc_edge_det u_e (.clk(clk), .rst_n(rst_n), .ce(ce), .pin(ext_irq_line_e),
    .trig(trig_r[14:12]), .hit(hit_e));
  swc_edge_det u_f (.clk(clk), .rst_n(rst_n), .ce(ce), .pin(ext_irq_line_f),
    .trig(trig_r[17:15]), .hit(hit_f));

  function automatic logic [2:0] lim_d(input logic [2:0] t);
    lim_d = (t == TRG_HIGH || t == TRG_LOW) ? TRG_RISE : t;
  endfunction

  // Wake sources
  wire ext_wake = hit_a | hit_b | hit_c | hit_e | hit_f; // [R06]
  wire [P0_W-1:0] p0_fall = p0_prev_r & ~port0_in & p0en_r;
  wire p0_wake = |p0_fall; // [R11]
  wire sleep_wake = ext_wake | p0_wake | ~reset_pin_n; // [R06]
  wire xsleep_wake = sleep_wake | bt_irq | ir_irq; // [R10] [R16]
  wire any_irq = ext_wake | hit_d | p0_wake | bt_irq | ir_irq | other_irq;
  wire [ST_W-1:0] ev = {sleep_wake & (st_r == SWC_SLEEP || st_r == SWC_XSLEEP),
    ir_irq, bt_irq, p0_wake, ext_wake | hit_d};

  // Wishbone decode
  wire req = wb_cyc_i & wb_stb_i & ~ack_r;
  // Write lands at the edge where the master sees ack
  wire wr = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = wr && wb_adr_i == OFF_CTRL;
  wire wr_stat = wr && wb_adr_i == OFF_STAT;
  wire wr_mask = wr && wb_adr_i == OFF_MASK;
  wire wr_trig = wr && wb_adr_i == OFF_TRIG;
  wire wr_osc = wr && wb_adr_i == OFF_OSC;
  wire wr_p0en = wr && wb_adr_i == OFF_P0EN;
  wire wr_bt = wr && wb_adr_i == OFF_BT;
  wire [31:0] rmux =
    wb_adr_i == OFF_CTRL ? {30'h0000_0000, ctrl_req_r} :
    wb_adr_i == OFF_STAT ? {27'h000_0000, stat_r} :
    wb_adr_i == OFF_MASK ? {27'h000_0000, mask_r} :
    wb_adr_i == OFF_TRIG ? {14'h0000, trig_r} :
    wb_adr_i == OFF_OSC ? {28'h000_0000, osc_r} :
    wb_adr_i == OFF_P0EN ? {{(32-P0_W){1'b0}}, p0en_r} :
    wb_adr_i == OFF_BT ? {30'h0000_0000, bts_r} :
    wb_adr_i == OFF_STATE ? {29'h0000_0000, st_r} : 32'h0000_0000;

  // State sequencing
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      SWC_RUN:
        if (wr_ctrl) // [R18]
        begin
          case (wb_dat_i[1:0])
            REQ_PAUSE: st_nxt = SWC_PAUSE;
            REQ_SLEEP: st_nxt = SWC_SLEEP;
            REQ_XSLEEP: st_nxt = SWC_XSLEEP;
            default: st_nxt = SWC_RUN;
          endcase
        end
      SWC_PAUSE:
        if (any_irq || !reset_pin_n)
          st_nxt = SWC_RUN; // [R04]
      SWC_SLEEP:
        if (sleep_wake)
          st_nxt = SWC_SETTLE; // [R06]
      SWC_XSLEEP:
        if (xsleep_wake)
          st_nxt = SWC_SETTLE; // [R10]
      SWC_SETTLE:
        if (settle_r == 16'(SETTLE_CYC - 1))
          st_nxt = SWC_RUN; // [R17]
      default: st_nxt = SWC_RUN;
    endcase
  end

  wire in_pause = st_r == SWC_PAUSE;
  wire in_sleep = st_r == SWC_SLEEP;
  wire in_xs = st_r == SWC_XSLEEP;
  assign core_run = st_r == SWC_RUN; // [R01] [R05] [R07] [R17]
  assign periph_run = ~(in_sleep | in_xs); // [R01] [R05] [R07]
  assign serial_run = ~(in_pause | in_sleep | in_xs); // [R02]
  assign bt_run = ~in_sleep; // [R07]
  assign ir_run = ~in_sleep; // [R07]
  // Pause keeps software oscillator choice; sleep forces all off, crystal sleep all but the crystal
  assign ceramic_osc_en = osc_r[0] & ~in_sleep & ~in_xs; // [R03] [R05] [R08]
  assign internal_resistor_cap_osc_en = osc_r[1] & ~in_sleep & ~in_xs; // [R08]
  assign tunable_osc_en = osc_r[2] & ~in_sleep & ~in_xs; // [R05] [R08]
  assign crystal_osc_en = in_xs ? xtal_keep_r : (osc_r[3] & ~in_sleep); // [R09]
  assign bt_clk_tick = bts_r == BTS_SUB ? subclk_tick :
    bts_r == BTS_SYS ? 1'b1 : bts_r == BTS_PRE ? prescaler_tick : 1'b0; // [R15]
  assign ext_d_hit = hit_d;
  assign irq = |(stat_r & mask_r);
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= SWC_RUN;
      ctrl_req_r <= REQ_NONE;
      stat_r <= '0;
      mask_r <= '0;
      trig_r <= '0;
      osc_r <= 4'hf;
      xtal_keep_r <= 1'b0;
      p0en_r <= '0;
      p0_prev_r <= '0;
      bts_r <= BTS_SUB;
      settle_r <= 16'h0000;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      ack_r <= req;
      if (req)
        rdat_r <= rmux;
      if (wr_ctrl)
        ctrl_req_r <= wb_dat_i[1:0];
      else if (st_nxt == SWC_RUN)
        ctrl_req_r <= REQ_NONE;
      if (st_r == SWC_RUN && st_nxt == SWC_XSLEEP)
        xtal_keep_r <= osc_r[3]; // [R09]
      settle_r <= (st_r == SWC_SETTLE) ? settle_r + 16'h0001 : 16'h0000;
      // Set wins over write-one-to-clear
      stat_r <= (stat_r & ~(wr_stat ? wb_dat_i[ST_W-1:0] : '0)) | ev;
      if (wr_mask)
        mask_r <= wb_dat_i[ST_W-1:0];
      if (wr_trig)
        trig_r <= wb_dat_i[17:0];
      if (wr_osc)
        osc_r <= wb_dat_i[3:0];
      if (wr_p0en)
        p0en_r <= wb_dat_i[P0_W-1:0];
      if (wr_bt)
        bts_r <= wb_dat_i[1:0];
      p0_prev_r <= port0_in;
    end
  end
endmodule
`default_nettype wire
